/* subtract_swap_dirload_exec.v */
// Functional notes
// RQ1: decode subtract, file selector 0 to 31
// RQ2: difference is file plus inverted accumulator plus one
// RQ3: dest bit picks accumulator or file
// RQ4: carry set when no borrow
// RQ5: carry cleared on borrow
// RQ6: decode swap, exchange file nibbles
// RQ7: dest bit picks accumulator or file
// RQ8: decode direction load from accumulator
// RQ9: selectors 5 to 7 load direction registers
// RQ10: carry lives at status bit zero
// RQ11: each instruction completes in one cycle
// RQ12: swap and direction load keep flags
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs.vh"

module subtract_swap_dirload_exec #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             clock,
    input  wire             sys_rst,
    // instruction word, valid for one instruction cycle
    input  wire [11:0]      instr,
    input  wire             instr_valid,
    // file register port
    output wire [4:0]       file_addr,
    input  wire [WIDTH-1:0] file_rdata,
    output reg  [WIDTH-1:0] file_wdata,
    output reg              file_we,
    // core state
    output reg  [WIDTH-1:0] accum_r,
    output reg  [WIDTH-1:0] status_r,
    // direction registers, selectors 5, 6, 7
    output reg  [WIDTH-1:0] dir_a_r,
    output reg  [WIDTH-1:0] dir_b_r,
    output reg  [WIDTH-1:0] dir_c_r,
    output reg              dir_we
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------

    // true when the word matches a masked opcode pattern
    function match_op;
        input [11:0] word;           // instruction word
        input [11:0] mask;           // opcode bits that count
        input [11:0] value;          // required value of those bits
        begin
            match_op = ((word & mask) == value);
        end
    endfunction

    // true when a direction selector names one register
    function sel_hit;
        input [2:0] sel;             // selector from the word
        input [2:0] code;            // selector of this register
        begin
            sel_hit = (sel == code);
        end
    endfunction

    // ----------------------------------------------------------------
    // decoded instruction and control
    // ----------------------------------------------------------------
    wire             is_sub;         // subtract pattern
    wire             is_swap;        // swap pattern
    wire             is_dir;         // direction load pattern
    wire             dest_file;      // dest bit
    wire [2:0]       dir_sel;        // direction selector
    wire             dir_ok;         // selector in 5..7
    // datapath results
    wire [WIDTH-1:0] alu_res;        // difference or swapped byte
    wire             alu_c;          // carry, set when no borrow
    wire             alu_h;          // half-carry flag from low nibble, set when no borrow
    wire             alu_z;          // difference is zero
    // routing and strobes
    wire             exec_any;       // subtract or swap this cycle
    wire             to_file;        // result goes to the file register
    wire             to_accum;       // result goes to the accumulator
    wire             flag_upd;       // subtract updates the flags
    wire             dir_go;         // accepted direction load
    wire             load_a;         // selector 5 hit
    wire             load_b;         // selector 6 hit
    wire             load_c;         // selector 7 hit
    // next values
    reg  [WIDTH-1:0] accum_nxt;      // accumulator next value
    reg  [WIDTH-1:0] status_nxt;     // status next value

    // pattern match, gated by the valid strobe
    assign is_sub    = instr_valid && match_op(instr, `OPC_SUB_MASK, `OPC_SUB_VAL);   // RQ1
    assign is_swap   = instr_valid && match_op(instr, `OPC_SWAP_MASK, `OPC_SWAP_VAL); // RQ6
    assign is_dir    = instr_valid && match_op(instr, `OPC_DIR_MASK, `OPC_DIR_VAL);   // RQ8

    // operand fields taken straight from the word
    assign dest_file = instr[`FLD_DEST_BIT];
    assign file_addr = instr[`FLD_FILE_HI:0];                                       // RQ1
    assign dir_sel   = instr[`FLD_DIR_HI:0];

    // 8 and 9 do not fit three bits; only 5..7 decode
    // selectors 0..4 share the pattern but act as no-ops here
    assign dir_ok    = (dir_sel >= `DIR_SEL_FIRST) && (dir_sel <= `DIR_SEL_LAST);  // RQ9

    // where the subtract or swap result lands
    assign exec_any  = is_sub || is_swap;
    assign to_file   = exec_any && dest_file;                                       // RQ3 RQ7
    assign to_accum  = exec_any && !dest_file;                                      // RQ3 RQ7

    // only the subtract touches the flags
    assign flag_upd  = is_sub;                                                      // RQ12

    // one load strobe per direction register
    assign dir_go    = is_dir && dir_ok;                                            // RQ9
    assign load_a    = dir_go && sel_hit(dir_sel, `DIR_SEL_A);                      // RQ8
    assign load_b    = dir_go && sel_hit(dir_sel, `DIR_SEL_B);                      // RQ8
    assign load_c    = dir_go && sel_hit(dir_sel, `DIR_SEL_C);                      // RQ8

    // ----------------------------------------------------------------
    // datapath
    // ----------------------------------------------------------------
    sub_alu #(
        .WIDTH     (WIDTH)
    ) u_alu (
        .file_val  (file_rdata),
        .acc_val   (accum_r),
        .do_swap   (is_swap),
        .result    (alu_res),
        .carry_out (alu_c),
        .half_out  (alu_h),
        .zero_out  (alu_z)
    );

    // ----------------------------------------------------------------
    // next value logic
    // ----------------------------------------------------------------

    // accumulator keeps its value unless a result targets it
    always @* begin
        if (to_accum) begin
            accum_nxt = alu_res;
        end else begin
            accum_nxt = accum_r;
        end
    end

    // flags copy the datapath on subtract, else hold
    always @* begin
        status_nxt = status_r;
        if (flag_upd) begin
            status_nxt[`STAT_CARRY] = alu_c; // RQ4 RQ5 RQ10
            status_nxt[`STAT_HALF]  = alu_h;
            status_nxt[`STAT_ZERO]  = alu_z;
        end
    end

    // ----------------------------------------------------------------
    // registers, one instruction per clock
    // ----------------------------------------------------------------

    // accumulator register
    always @(posedge clock) begin // RQ11
        if (sys_rst) begin
            accum_r <= `ACC_RESET;
        end else begin
            accum_r <= accum_nxt;
        end
    end

    // status register; unused upper bits stay zero
    always @(posedge clock) begin // RQ11
        if (sys_rst) begin
            status_r <= {WIDTH{1'b0}};
        end else begin
            status_r <= status_nxt;
        end
    end

    // file register write port, one-cycle strobe
    // the write lands one cycle after the instruction, so a
    // back-to-back read of the same register must be ordered
    // by the core; nothing is forwarded here
    always @(posedge clock) begin // RQ11
        if (sys_rst) begin
            file_we    <= 1'b0;
            file_wdata <= {WIDTH{1'b0}};
        end else begin
            // strobe follows the target decode
            file_we <= to_file;
            if (to_file) begin
                // data holds between writes
                file_wdata <= alu_res;
            end
        end
    end

    // direction registers and their load strobe
    always @(posedge clock) begin // RQ11
        if (sys_rst) begin
            dir_we  <= 1'b0;
            dir_a_r <= `DIR_RESET;
            dir_b_r <= `DIR_RESET;
            dir_c_r <= `DIR_RESET;
        end else begin
            // strobe for accepted loads only
            dir_we <= dir_go;                // RQ8
            // accumulator to selected direction register
            if (load_a) begin
                dir_a_r <= accum_r;
            end
            if (load_b) begin
                dir_b_r <= accum_r;
            end
            if (load_c) begin
                dir_c_r <= accum_r;
            end
        end
    end

endmodule // subtract_swap_dirload_exec

`default_nettype wire

/* exec_regs.vh */
`ifndef EXEC_REGS_VH
`define EXEC_REGS_VH

// ----------------------------------------------------------------
// instruction patterns (12-bit words)
// ----------------------------------------------------------------
`define OPC_SUB_MASK     12'hfc0
`define OPC_SUB_VAL      12'h080
`define OPC_SWAP_MASK    12'hfc0
`define OPC_SWAP_VAL     12'h380
`define OPC_DIR_MASK     12'hff8
`define OPC_DIR_VAL      12'h000

// ----------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------
`define FLD_DEST_BIT     5
`define FLD_FILE_HI      4
`define FLD_DIR_HI       2

// ----------------------------------------------------------------
// status bit positions and reset values
// ----------------------------------------------------------------
`define STAT_CARRY       0
`define STAT_HALF        1
`define STAT_ZERO        2
`define ACC_RESET        8'h00
`define DIR_RESET        8'hff
`define DIR_SEL_FIRST    3'h5
`define DIR_SEL_LAST     3'h7
`define DIR_SEL_A        3'h5
`define DIR_SEL_B        3'h6
`define DIR_SEL_C        3'h7

// ----------------------------------------------------------------
// nibble boundaries inside a byte
// ----------------------------------------------------------------
`define NIB_LO_HI        3
`define NIB_HI_LO        4

`endif

/* sub_alu.v */
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs.vh"

// ----------------------------------------------------------------
// subtract / swap datapath, purely combinational
// ----------------------------------------------------------------
module sub_alu #(
    parameter WIDTH = 8
) (
    // operands
    input  wire [WIDTH-1:0] file_val,
    input  wire [WIDTH-1:0] acc_val,
    input  wire             do_swap,
    // results
    output reg  [WIDTH-1:0] result,
    output reg              carry_out,
    output reg              half_out,
    output reg              zero_out
);

    // wide sums keep carry from the top bit
    reg [WIDTH:0]   full_sum;
    reg [`NIB_HI_LO:0] low_sum;

    // two's complement add of inverted accumulator plus one
    always @* begin
        full_sum  = {1'b0, file_val} + {1'b0, ~acc_val} + {{WIDTH{1'b0}}, 1'b1}; // RQ2
        low_sum   = {1'b0, file_val[`NIB_LO_HI:0]} + {1'b0, ~acc_val[`NIB_LO_HI:0]} + {{`NIB_HI_LO{1'b0}}, 1'b1};
        carry_out = full_sum[WIDTH];      // RQ4 RQ5
        half_out  = low_sum[`NIB_HI_LO];
        if (do_swap) begin
            result = {file_val[`NIB_LO_HI:0], file_val[WIDTH-1:`NIB_HI_LO]}; // RQ6
        end else begin
            result = full_sum[WIDTH-1:0];
        end
        zero_out  = (full_sum[WIDTH-1:0] == {WIDTH{1'b0}});
    end

endmodule // sub_alu

`default_nettype wire

/* exec_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// execute unit checker
// ------------------------------------
module exec_props (
    // port view of the unit
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic [11:0] instr,
    input wire logic        instr_valid,
    input wire logic [4:0]  file_addr,
    input wire logic [7:0]  file_rdata,
    input wire logic [7:0]  file_wdata,
    input wire logic        file_we,
    input wire logic [7:0]  accum_r,
    input wire logic [7:0]  status_r,
    input wire logic [7:0]  dir_a_r,
    input wire logic [7:0]  dir_b_r,
    input wire logic [7:0]  dir_c_r,
    input wire logic        dir_we
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // decoded instruction kinds
    wire sub_i = instr_valid && instr[11:6] == 6'h02;
    wire swp_i = instr_valid && instr[11:6] == 6'h0e;
    wire dir_i = instr_valid && instr[11:3] == 9'h000;
    a_addr_follow: assert property (file_addr == instr[4:0]) else $error("addr");
    a_sub_file: assert property (sub_i && instr[5] |=>
        file_we && file_wdata == $past(file_rdata) - $past(accum_r)) else $error("sub file");
    a_sub_accum: assert property (sub_i && !instr[5] |=>
        !file_we && accum_r == $past(file_rdata) - $past(accum_r)) else $error("sub acc");
    a_sub_carry: assert property (sub_i |=>
        status_r[0] == ($past(file_rdata) >= $past(accum_r))) else $error("carry");
    a_swap_accum: assert property (swp_i && !instr[5] |=>
        accum_r == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}) else $error("swap acc");
    a_swap_file: assert property (swp_i && instr[5] |=>
        file_we && file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}) else $error("swap f");
    a_flags_kept: assert property (swp_i || dir_i |=> $stable(status_r)) else $error("flags");
    a_dir_load: assert property (dir_i && instr[2:0] == 3'h6 |=>
        dir_we && dir_b_r == $past(accum_r)) else $error("dir load");
    a_dir_refuse: assert property (dir_i && instr[2:0] < 3'h5 |=> !dir_we) else $error("dir refuse");
    c_sub_file: cover property (sub_i && instr[5]);
    c_swap: cover property (swp_i);
    c_dir_last: cover property (dir_i && instr[2:0] == 3'h7);
endmodule // exec_props
bind subtract_swap_dirload_exec exec_props u_props (.clock, .sys_rst, .instr, .instr_valid, .file_addr,
    .file_rdata, .file_wdata, .file_we, .accum_r, .status_r, .dir_a_r, .dir_b_r, .dir_c_r, .dir_we);
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [11:0] instr = 12'h000;
    logic        instr_valid = 1'b0;
    logic [7:0]  file_rdata = 8'h00;
    wire  [4:0]  file_addr;
    wire  [7:0]  file_wdata, accum_r, status_r, dir_a_r, dir_b_r, dir_c_r;
    wire         file_we, dir_we;
    int          bad_count = 0;
    int          n_compared = 0;
    always #20 clock = ~clock;
    subtract_swap_dirload_exec dut (.clock, .sys_rst, .instr, .instr_valid, .file_addr, .file_rdata,
        .file_wdata, .file_we, .accum_r, .status_r, .dir_a_r, .dir_b_r, .dir_c_r, .dir_we);
    // byte compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one instruction, then judge result ports one edge later
    task automatic run_op(input logic [11:0] i, input logic [7:0] r, a, we, wd, st);
        @(posedge clock);
        instr <= i;
        instr_valid <= 1'b1;
        file_rdata <= r;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
        chk({3'h0, file_addr}, {3'h0, i[4:0]});
        chk(accum_r, a);
        chk({7'h0, file_we}, we);
        if (we[0]) chk(file_wdata, wd);
        chk(status_r, st);
    endtask
    // subtract and swap sequence
    task automatic t_arith;
        run_op(12'h380, 8'h20, 8'h02, 8'h00, 8'h00, 8'h00);
        run_op(12'h0a3, 8'h03, 8'h02, 8'h01, 8'h01, 8'h03);
        run_op(12'h085, 8'h01, 8'hff, 8'h00, 8'h00, 8'h00);
        run_op(12'h380, 8'h20, 8'h02, 8'h00, 8'h00, 8'h00);
        run_op(12'h0bf, 8'h02, 8'h02, 8'h01, 8'h00, 8'h07);
        run_op(12'h3a4, 8'ha5, 8'h02, 8'h01, 8'h5a, 8'h07);
        run_op(12'h384, 8'ha5, 8'h5a, 8'h00, 8'h00, 8'h07);
    endtask
    // direction loads, refused selector first
    task automatic t_dir;
        run_op(12'h004, 8'h00, 8'h5a, 8'h00, 8'h00, 8'h07);
        chk({7'h0, dir_we}, 8'h00);
        chk(dir_a_r, 8'hff);
        for (int s = 5; s < 8; s++) begin
            run_op(12'(s), 8'h00, 8'h5a, 8'h00, 8'h00, 8'h07);
            chk({7'h0, dir_we}, 8'h01);
            chk(s == 5 ? dir_a_r : s == 6 ? dir_b_r : dir_c_r, 8'h5a);
        end
    endtask
    // verdict and end of run
    task automatic complete_run;
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        chk(accum_r, 8'h00);
        chk(dir_c_r, 8'hff);
        t_arith();
        t_dir();
        complete_run();
    end
    // hang guard
    initial begin
        repeat (400) @(posedge clock);
        bad_count++;
        complete_run();
    end
endmodule // testbench
`default_nettype wire
